//--- hw/gdfm_pkg.sv
// gdfm_pkg: constants and types for the gate driver fault manager
// assumes a 50 MHz core clock and synchronous pin inputs
package gdfm_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 20;
	// low phase of the enable reset pulse window, in ns
	localparam int RESET_PULSE_MAX_NS = 40000;
	localparam int RESET_PULSE_CYCLES = RESET_PULSE_MAX_NS / CLK_PERIOD_NS;
	localparam int PULSE_CNT_W = 12;

	// ****************************************************************
	// overcurrent mode field encoding
	// ****************************************************************
	localparam logic [1:0] OVERCURRENT_MODE_FIELD_LATCH = 2'h0;
	localparam logic [1:0] OVERCURRENT_MODE_FIELD_RETRY = 2'h1;
	localparam logic [1:0] OVERCURRENT_MODE_FIELD_REPORT = 2'h2;
	localparam logic [1:0] OVERCURRENT_MODE_FIELD_OFF = 2'h3;

	// ****************************************************************
	// reset values of configuration bits
	// ****************************************************************
	localparam logic RST_WARNING_REPORT_ENABLE = 1'h0;
	localparam logic RST_SENSE_OC_DISABLE = 1'h0;
	localparam logic [1:0] RST_OVERCURRENT_MODE_FIELD = 2'h0;

	// ****************************************************************
	// power state
	// ****************************************************************
	typedef enum logic [1:0] {
		GDFM_SLEEP = 2'b00,
		GDFM_WAKE = 2'b01,
		GDFM_RUN = 2'b11,
		GDFM_PULSE = 2'b10
	} gdfm_state_type;

endpackage : gdfm_pkg

//--- hw/gdfm_config.sv
// gdfm_config: configuration bits written by the controller
// assumes writes are qualified single-cycle strobes from the serial port
`timescale 1ns/1ps
module gdfm_config
	import gdfm_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sleep_i,
	input wire logic cfg_we_i,
	input wire logic cfg_warning_report_enable_i,
	input wire logic cfg_sense_overcurrent_disable_i,
	input wire logic [1:0] cfg_overcurrent_mode_field_i,
	output logic warning_report_enable_o,
	output logic sense_overcurrent_disable_o,
	output logic [1:0] overcurrent_mode_field_o
);

	logic next_wre;
	logic next_sod;
	logic [1:0] next_ocm;

	// ****************************************************************
	// next value
	// ****************************************************************
	always_comb begin
		next_wre = warning_report_enable_o;
		next_sod = sense_overcurrent_disable_o;
		next_ocm = overcurrent_mode_field_o;
		if (sleep_i) begin
			// defaults restored in sleep
			next_wre = RST_WARNING_REPORT_ENABLE;
			next_sod = RST_SENSE_OC_DISABLE;
			next_ocm = RST_OVERCURRENT_MODE_FIELD;
		end else if (cfg_we_i) begin
			next_wre = cfg_warning_report_enable_i;
			next_sod = cfg_sense_overcurrent_disable_i;
			next_ocm = cfg_overcurrent_mode_field_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			warning_report_enable_o <= RST_WARNING_REPORT_ENABLE;
			sense_overcurrent_disable_o <= RST_SENSE_OC_DISABLE;
			overcurrent_mode_field_o <= RST_OVERCURRENT_MODE_FIELD;
		end else begin
			warning_report_enable_o <= next_wre;
			sense_overcurrent_disable_o <= next_sod;
			overcurrent_mode_field_o <= next_ocm;
		end
	end

endmodule : gdfm_config

//--- hw/gdfm_pulse.sv
// gdfm_pulse: classifies low phases of the enable pin
// assumes enable_i is synchronous to clk_i
`timescale 1ns/1ps
module gdfm_pulse
	import gdfm_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	output logic reset_pulse_o,
	output logic sleep_req_o
);

	logic [PULSE_CNT_W-1:0] low_cnt;
	logic [PULSE_CNT_W-1:0] next_low_cnt;
	logic enable_q;
	logic next_reset_pulse;
	logic next_sleep_req;

	// ****************************************************************
	// low phase timing
	// ****************************************************************
	always_comb begin
		next_low_cnt = low_cnt;
		next_reset_pulse = 1'b0;
		next_sleep_req = sleep_req_o;
		if (!enable_i) begin
			if (low_cnt < PULSE_CNT_W'(RESET_PULSE_CYCLES))
				next_low_cnt = low_cnt + PULSE_CNT_W'(1);
			else
				next_sleep_req = 1'b1;
		end else begin
			next_low_cnt = '0;
			next_sleep_req = 1'b0;
			// short low phase ended by a rising edge
			if (!enable_q && !sleep_req_o)
				next_reset_pulse = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_cnt <= '0;
			enable_q <= 1'b0;
			reset_pulse_o <= 1'b0;
			sleep_req_o <= 1'b1;
		end else begin
			low_cnt <= next_low_cnt;
			enable_q <= enable_i;
			reset_pulse_o <= next_reset_pulse;
			sleep_req_o <= next_sleep_req;
		end
	end

endmodule : gdfm_pulse

//--- hw/gdfm_top.sv
// gdfm_top: fault supervision and power state of a three-phase gate driver
// assumes all inputs synchronous to clk_i; comparators deliver clean levels
//
// What this block does
// - warning sets status, drivers keep running
// - warning status clears itself with condition
// - report enable routes warning to pin
// - shutdown disables gates, pump, pulls pin
// - shutdown latches flags, recovers automatically
// - shutdown flag held until clear command
// - shutdown protection has no disable
// - sense overcurrent ignored when disabled
// - enable held low past 40 us enters sleep
// - sleep turns off drivers, regulators, bus
// - sleep restores all register defaults
// - sleep or undervoltage pulls gates off
// - enable with good supply runs everything
// - reset pulse clears latched faults only, except an overcurrent latched in retry mode
`timescale 1ns/1ps
module gdfm_top
	import gdfm_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	input wire logic supply_undervoltage_i,
	input wire logic overtemp_warning_i,
	input wire logic thermal_shutdown_i,
	input wire logic sense_overcurrent_i,
	input wire logic retry_done_i,
	input wire logic clear_fault_bit_i,
	input wire logic cfg_we_i,
	input wire logic cfg_warning_report_enable_i,
	input wire logic cfg_sense_overcurrent_disable_i,
	input wire logic [1:0] cfg_overcurrent_mode_field_i,
	output logic fault_out_n_o,
	output logic fault_bit_o,
	output logic overtemp_warning_flag_o,
	output logic thermal_shutdown_flag_o,
	output logic sense_overcurrent_flag_o,
	output logic gate_drive_enable_o,
	output logic gate_pulldown_o,
	output logic charge_pump_enable_o,
	output logic low_side_gate_regulator_enable_o,
	output logic digital_supply_regulator_enable_o,
	output logic sense_amp_enable_o,
	output logic serial_bus_enable_o,
	output logic sleep_o
);

	gdfm_state_type state;
	gdfm_state_type next_state;
	logic reset_pulse;
	logic sleep_req;
	logic sleeping;
	logic warning_report_enable;
	logic sense_overcurrent_disable;
	logic [1:0] overcurrent_mode_field;
	logic sense_oc_armed;
	logic sense_oc_stops;
	logic clear_cmd;
	logic tsd_latch;
	logic next_tsd_latch;
	logic soc_latch;
	logic next_soc_latch;
	logic warn_reported;
	logic next_fault_n;
	logic next_fault_bit;
	logic next_gate_en;
	logic next_pump_en;
	logic next_rails_en;

	// ****************************************************************
	// submodules
	// ****************************************************************
	gdfm_pulse u_pulse (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.enable_i(enable_i),
		.reset_pulse_o(reset_pulse),
		.sleep_req_o(sleep_req)
	);

	gdfm_config u_config (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.sleep_i(sleeping),
		.cfg_we_i(cfg_we_i),
		.cfg_warning_report_enable_i(cfg_warning_report_enable_i),
		.cfg_sense_overcurrent_disable_i(cfg_sense_overcurrent_disable_i),
		.cfg_overcurrent_mode_field_i(cfg_overcurrent_mode_field_i),
		.warning_report_enable_o(warning_report_enable),
		.sense_overcurrent_disable_o(sense_overcurrent_disable),
		.overcurrent_mode_field_o(overcurrent_mode_field)
	);

	// ****************************************************************
	// power state
	// ****************************************************************
	assign sleeping = (state == GDFM_SLEEP);

	always_comb begin
		next_state = state;
		unique case (state)
			GDFM_SLEEP: begin
				if (!sleep_req && !supply_undervoltage_i)
					next_state = GDFM_WAKE;
			end
			GDFM_WAKE: begin
				if (sleep_req || supply_undervoltage_i)
					next_state = GDFM_SLEEP;
				else
					next_state = GDFM_RUN;
			end
			GDFM_RUN: begin
				if (sleep_req || supply_undervoltage_i)
					next_state = GDFM_SLEEP;
				else if (!enable_i)
					next_state = GDFM_PULSE;
			end
			GDFM_PULSE: begin
				// short low phase: everything stays powered
				if (sleep_req || supply_undervoltage_i)
					next_state = GDFM_SLEEP;
				else if (enable_i)
					next_state = GDFM_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			state <= GDFM_SLEEP;
		else
			state <= next_state;
	end

	// ****************************************************************
	// fault latches
	// ****************************************************************
	assign clear_cmd = clear_fault_bit_i || reset_pulse;
	assign sense_oc_armed = (overcurrent_mode_field != OVERCURRENT_MODE_FIELD_OFF) &&
		!sense_overcurrent_disable;
	assign sense_oc_stops = soc_latch &&
		(overcurrent_mode_field != OVERCURRENT_MODE_FIELD_REPORT);
	assign warn_reported = overtemp_warning_i && warning_report_enable;

	always_comb begin
		next_tsd_latch = tsd_latch;
		next_soc_latch = soc_latch;
		if (sleeping) begin
			next_tsd_latch = 1'b0;
			next_soc_latch = 1'b0;
		end else begin
			// set wins over clear
			if (clear_cmd)
				next_tsd_latch = 1'b0;
			if (thermal_shutdown_i)
				next_tsd_latch = 1'b1;
			if (clear_cmd && !sense_overcurrent_i &&
				overcurrent_mode_field != OVERCURRENT_MODE_FIELD_RETRY)
				next_soc_latch = 1'b0;
			if (retry_done_i && overcurrent_mode_field == OVERCURRENT_MODE_FIELD_RETRY)
				next_soc_latch = 1'b0;
			if (!sense_oc_armed)
				next_soc_latch = 1'b0;
			else if (sense_overcurrent_i)
				next_soc_latch = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tsd_latch <= 1'b0;
			soc_latch <= 1'b0;
		end else begin
			tsd_latch <= next_tsd_latch;
			soc_latch <= next_soc_latch;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_comb begin
		next_fault_n = 1'b1;
		next_fault_bit = 1'b0;
		next_gate_en = 1'b0;
		next_pump_en = 1'b0;
		next_rails_en = 1'b0;
		if (!sleeping) begin
			// thermal shutdown active only while the condition stands
			next_fault_n = !(thermal_shutdown_i || warn_reported ||
				soc_latch || supply_undervoltage_i);
			next_fault_bit = thermal_shutdown_i || tsd_latch ||
				warn_reported || soc_latch;
			next_gate_en = !thermal_shutdown_i && !sense_oc_stops &&
				!supply_undervoltage_i && (next_state != GDFM_SLEEP);
			next_pump_en = !thermal_shutdown_i &&
				(next_state != GDFM_SLEEP);
			next_rails_en = (next_state != GDFM_SLEEP);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fault_out_n_o <= 1'b1;
			fault_bit_o <= 1'b0;
			overtemp_warning_flag_o <= 1'b0;
			thermal_shutdown_flag_o <= 1'b0;
			sense_overcurrent_flag_o <= 1'b0;
			gate_drive_enable_o <= 1'b0;
			gate_pulldown_o <= 1'b1;
			charge_pump_enable_o <= 1'b0;
			low_side_gate_regulator_enable_o <= 1'b0;
			digital_supply_regulator_enable_o <= 1'b0;
			sense_amp_enable_o <= 1'b0;
			serial_bus_enable_o <= 1'b0;
			sleep_o <= 1'b1;
		end else begin
			fault_out_n_o <= next_fault_n;
			fault_bit_o <= next_fault_bit;
			overtemp_warning_flag_o <= overtemp_warning_i && !sleeping;
			thermal_shutdown_flag_o <= next_tsd_latch;
			sense_overcurrent_flag_o <= next_soc_latch;
			gate_drive_enable_o <= next_gate_en;
			gate_pulldown_o <= !next_gate_en;
			charge_pump_enable_o <= next_pump_en;
			low_side_gate_regulator_enable_o <= next_rails_en;
			digital_supply_regulator_enable_o <= next_rails_en;
			sense_amp_enable_o <= next_rails_en;
			serial_bus_enable_o <= next_rails_en;
			sleep_o <= (next_state == GDFM_SLEEP);
		end
	end

endmodule : gdfm_top

//--- tb/gdfm_chk.sv
// gdfm_chk: concurrent checks on the fault manager top ports
// assumes bound to gdfm_top, single clock domain
`timescale 1ns/1ps
module gdfm_chk
	import gdfm_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic enable_i,
	input wire logic supply_undervoltage_i,
	input wire logic overtemp_warning_i,
	input wire logic thermal_shutdown_i,
	input wire logic clear_fault_bit_i,
	input wire logic fault_out_n_o,
	input wire logic fault_bit_o,
	input wire logic overtemp_warning_flag_o,
	input wire logic thermal_shutdown_flag_o,
	input wire logic gate_drive_enable_o,
	input wire logic gate_pulldown_o,
	input wire logic charge_pump_enable_o,
	input wire logic low_side_gate_regulator_enable_o,
	input wire logic digital_supply_regulator_enable_o,
	input wire logic sense_amp_enable_o,
	input wire logic serial_bus_enable_o,
	input wire logic sleep_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_tsd_off;
		thermal_shutdown_i |=> !gate_drive_enable_o && !charge_pump_enable_o
			&& !fault_out_n_o;
	endproperty
	a_tsd_off: assert property (p_tsd_off) else $error("shutdown not acted");
	property p_tsd_latch;
		thermal_shutdown_i && !sleep_o |=> sleep_o
			|| (thermal_shutdown_flag_o && fault_bit_o);
	endproperty
	a_tsd_latch: assert property (p_tsd_latch) else $error("flags not set");
	property p_tsd_hold;
		(enable_i && !clear_fault_bit_i)[*4] ##0 thermal_shutdown_flag_o
			|=> thermal_shutdown_flag_o;
	endproperty
	a_tsd_hold: assert property (p_tsd_hold) else $error("flag lost");
	property p_otw_set;
		overtemp_warning_i && !sleep_o |=> overtemp_warning_flag_o || sleep_o;
	endproperty
	a_otw_set: assert property (p_otw_set) else $error("warning not set");
	property p_otw_clr;
		!overtemp_warning_i |=> !overtemp_warning_flag_o;
	endproperty
	a_otw_clr: assert property (p_otw_clr) else $error("warning stuck");
	property p_sleep_off;
		sleep_o |-> gate_pulldown_o && !gate_drive_enable_o
			&& !charge_pump_enable_o && !low_side_gate_regulator_enable_o
			&& !digital_supply_regulator_enable_o && !sense_amp_enable_o
			&& !serial_bus_enable_o;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("sleep rails on");
	property p_uv_off;
		supply_undervoltage_i |=> gate_pulldown_o && !gate_drive_enable_o;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("uv gates on");
	property p_wake;
		$fell(sleep_o) && enable_i && !supply_undervoltage_i
			&& !thermal_shutdown_i |-> ##[1:3] (charge_pump_enable_o
			&& low_side_gate_regulator_enable_o && serial_bus_enable_o
			&& digital_supply_regulator_enable_o);
	endproperty
	a_wake: assert property (p_wake) else $error("rails not up");
	c_tsd: cover property (thermal_shutdown_flag_o && !thermal_shutdown_i);
	c_sleep: cover property ($rose(sleep_o));
	c_warn: cover property (overtemp_warning_flag_o && !fault_out_n_o);
endmodule : gdfm_chk
bind gdfm_top gdfm_chk gdfm_chk_i (.clk_i, .nrst_i, .enable_i,
	.supply_undervoltage_i, .overtemp_warning_i, .thermal_shutdown_i,
	.clear_fault_bit_i, .fault_out_n_o, .fault_bit_o, .overtemp_warning_flag_o,
	.thermal_shutdown_flag_o, .gate_drive_enable_o, .gate_pulldown_o,
	.charge_pump_enable_o, .low_side_gate_regulator_enable_o,
	.digital_supply_regulator_enable_o, .sense_amp_enable_o,
	.serial_bus_enable_o, .sleep_o);

//--- tb/gdfm_ctrl_model.sv
// gdfm_ctrl_model: motor controller driving the enable pin
// assumes a one-cycle pulse_req_i strobe and a level sleep_req_i, both taken on the rising clk_i edge
`timescale 1ns/1ps
module gdfm_ctrl_model #(
	parameter int PULSE_LOW = 10,
	parameter int SLEEP_HOLD = 2100,
	parameter int WAKE_WAIT = 8
) (
	input wire logic clk_i,
	input wire logic pulse_req_i,
	input wire logic sleep_req_i,
	output logic enable_o,
	output logic ready_o
);
	initial begin
		enable_o = 1'b1;
		ready_o = 1'b1;
	end
	always begin
		@(posedge clk_i);
		if (pulse_req_i || sleep_req_i) begin
			ready_o <= 1'b0;
			enable_o <= 1'b0;
			if (pulse_req_i) begin
				repeat (PULSE_LOW) @(posedge clk_i);
			end else begin
				repeat (SLEEP_HOLD) @(posedge clk_i);
				while (sleep_req_i) @(posedge clk_i);
			end
			enable_o <= 1'b1;
			repeat (WAKE_WAIT) @(posedge clk_i);
			ready_o <= 1'b1;
		end
	end
endmodule : gdfm_ctrl_model

//--- tb/gdfm_tb_top.sv
// gdfm_tb_top: directed tests of the gate driver fault manager
// assumes gdfm_top with the controller model on the enable pin
`timescale 1ns/1ps
module gdfm_tb_top;
	import gdfm_pkg::*;
	logic clk_i, nrst_i, enable_i, supply_undervoltage_i, overtemp_warning_i;
	logic thermal_shutdown_i, sense_overcurrent_i, retry_done_i, cfg_we_i;
	logic clear_fault_bit_i, cfg_warning_report_enable_i;
	logic cfg_sense_overcurrent_disable_i;
	logic [1:0] cfg_overcurrent_mode_field_i;
	logic fault_out_n_o, fault_bit_o, overtemp_warning_flag_o, sleep_o;
	logic thermal_shutdown_flag_o, sense_overcurrent_flag_o, gate_pulldown_o;
	logic gate_drive_enable_o, charge_pump_enable_o, sense_amp_enable_o;
	logic low_side_gate_regulator_enable_o, digital_supply_regulator_enable_o;
	logic serial_bus_enable_o, pulse_req, sleep_req, ready;
	int err_count = 0;
	int cmp_count = 0;
	gdfm_top gdfm_top_i (.clk_i, .nrst_i, .enable_i, .supply_undervoltage_i,
		.overtemp_warning_i, .thermal_shutdown_i, .sense_overcurrent_i,
		.retry_done_i, .clear_fault_bit_i, .cfg_we_i,
		.cfg_warning_report_enable_i, .cfg_sense_overcurrent_disable_i,
		.cfg_overcurrent_mode_field_i, .fault_out_n_o, .fault_bit_o,
		.overtemp_warning_flag_o, .thermal_shutdown_flag_o,
		.sense_overcurrent_flag_o, .gate_drive_enable_o, .gate_pulldown_o,
		.charge_pump_enable_o, .low_side_gate_regulator_enable_o,
		.digital_supply_regulator_enable_o, .sense_amp_enable_o,
		.serial_bus_enable_o, .sleep_o);
	gdfm_ctrl_model gdfm_ctrl_model_i (.clk_i, .pulse_req_i(pulse_req),
		.sleep_req_i(sleep_req), .enable_o(enable_i), .ready_o(ready));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	function automatic logic [4:0] st();
		return {gate_pulldown_o, gate_drive_enable_o, charge_pump_enable_o,
			fault_out_n_o, fault_bit_o};
	endfunction : st
	function automatic logic [4:0] fl();
		return {1'b0, overtemp_warning_flag_o, thermal_shutdown_flag_o,
			sense_overcurrent_flag_o, sleep_o};
	endfunction : fl
	function automatic logic [4:0] rails();
		return {1'b0, low_side_gate_regulator_enable_o, serial_bus_enable_o,
			digital_supply_regulator_enable_o, sense_amp_enable_o};
	endfunction : rails
	task chk(input logic [4:0] seen, input logic [4:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task tick();
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
	endtask : tick
	task wcfg(input logic rep, input logic dis, input logic [1:0] mode);
		@(posedge clk_i);
		cfg_warning_report_enable_i <= rep;
		cfg_sense_overcurrent_disable_i <= dis;
		cfg_overcurrent_mode_field_i <= mode;
		cfg_we_i <= 1'b1;
		@(posedge clk_i);
		cfg_we_i <= 1'b0;
	endtask : wcfg
	task wait_ready();
		repeat (3000) begin
			@(negedge clk_i);
			if (ready === 1'b1) break;
		end
		chk({4'h0, ready}, 5'h01);
		tick();
	endtask : wait_ready
	task warn(input logic [4:0] exp);
		@(posedge clk_i);
		overtemp_warning_i <= 1'b1;
		tick();
		chk(st(), exp);
		@(posedge clk_i);
		overtemp_warning_i <= 1'b0;
		tick();
		chk(fl(), 5'h00);
	endtask : warn
	task t_warn();
		@(posedge clk_i);
		overtemp_warning_i <= 1'b1;
		tick();
		chk(fl(), 5'h08);
		warn(5'h0e);
		wcfg(1'b1, 1'b0, 2'h0);
		warn(5'h0d);
		chk(st(), 5'h0e);
		$display("warning test done");
	endtask : t_warn
	task thermal_shutdown_flag();
		@(posedge clk_i);
		thermal_shutdown_i <= 1'b1;
		tick();
		chk(st(), 5'h11);
		chk(fl(), 5'h04);
		@(posedge clk_i);
		thermal_shutdown_i <= 1'b0;
		tick();
		chk(st(), 5'h0f);
		chk(fl(), 5'h04);
	endtask : thermal_shutdown_flag
	task t_tsd();
		wcfg(1'b1, 1'b1, 2'h3);
		thermal_shutdown_flag();
		@(posedge clk_i);
		clear_fault_bit_i <= 1'b1;
		@(posedge clk_i);
		clear_fault_bit_i <= 1'b0;
		tick();
		chk(fl(), 5'h00);
		thermal_shutdown_flag();
		@(posedge clk_i);
		pulse_req <= 1'b1;
		@(posedge clk_i);
		pulse_req <= 1'b0;
		wait_ready();
		chk(fl(), 5'h00);
		chk(rails(), 5'h0f);
		warn(5'h0d);
		$display("shutdown test done");
	endtask : t_tsd
	task t_sense();
		for (int i = 0; i < 2; i++) begin
			wcfg(1'b0, i[0], i[0] ? 2'h0 : 2'h3);
			@(posedge clk_i);
			sense_overcurrent_i <= 1'b1;
			tick();
			chk(st(), 5'h0e);
			chk(fl(), 5'h00);
			@(posedge clk_i);
			sense_overcurrent_i <= 1'b0;
		end
		@(posedge clk_i);
		supply_undervoltage_i <= 1'b1;
		tick();
		chk(st() & 5'h18, 5'h10);
		@(posedge clk_i);
		supply_undervoltage_i <= 1'b0;
		tick();
		chk(st(), 5'h0e);
		$display("sense and supply test done");
	endtask : t_sense
	task t_ocp();
		logic [4:0] held;
		for (int m = 0; m < 3; m++) begin
			wcfg(1'b0, 1'b0, 2'(m));
			held = (2'(m) == OVERCURRENT_MODE_FIELD_REPORT) ? 5'h0d : 5'h15;
			@(posedge clk_i);
			sense_overcurrent_i <= 1'b1;
			tick();
			chk(st(), held);
			chk(fl(), 5'h02);
			@(posedge clk_i);
			sense_overcurrent_i <= 1'b0;
			@(posedge clk_i);
			clear_fault_bit_i <= 1'b1;
			@(posedge clk_i);
			clear_fault_bit_i <= 1'b0;
			tick();
			chk(fl(), (2'(m) == OVERCURRENT_MODE_FIELD_RETRY) ? 5'h02 : 5'h00);
			@(posedge clk_i);
			retry_done_i <= 1'b1;
			@(posedge clk_i);
			retry_done_i <= 1'b0;
			tick();
			chk(st(), 5'h0e);
			chk(fl(), 5'h00);
		end
		$display("overcurrent test done");
	endtask : t_ocp
	task t_sleep();
		wcfg(1'b1, 1'b0, 2'h2);
		@(posedge clk_i);
		sleep_req <= 1'b1;
		repeat (2110) @(posedge clk_i);
		@(negedge clk_i);
		chk(fl() & 5'h01, 5'h01);
		chk(rails(), 5'h00);
		chk(st() & 5'h1c, 5'h10);
		@(posedge clk_i);
		sleep_req <= 1'b0;
		wait_ready();
		chk(rails(), 5'h0f);
		warn(5'h0e);
		$display("sleep test done");
	endtask : t_sleep
	task wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
	initial begin
		{nrst_i, supply_undervoltage_i, overtemp_warning_i} = 3'h0;
		{thermal_shutdown_i, sense_overcurrent_i, retry_done_i} = 3'h0;
		{clear_fault_bit_i, cfg_we_i, cfg_warning_report_enable_i} = 3'h0;
		{cfg_sense_overcurrent_disable_i, pulse_req, sleep_req} = 3'h0;
		cfg_overcurrent_mode_field_i = 2'h0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		chk(rails(), 5'h0f);
		t_warn();
		t_tsd();
		t_sense();
		t_ocp();
		t_sleep();
		wrap_up();
	end
endmodule : gdfm_tb_top
